// [pin_partner.sv]
`timescale 1ns/1ps
// Far side of the unit: port pin wires and the keyboard reset line
module pin_partner (
  input  wire logic [7:0] out5,
  input  wire logic [7:0] oe5,
  input  wire logic [7:0] ext5,
  output logic      [7:0] lvl5,
  input  wire logic [7:0] out6,
  input  wire logic [7:0] oe6,
  input  wire logic [7:0] ext6,
  output logic      [7:0] lvl6,
  input  wire logic       kb_out,
  input  wire logic       kb_oe,
  output logic            kb_lvl
);
  // Driven bits follow the unit, released bits the outside driver
  assign lvl5 = (out5 & oe5) | (ext5 & ~oe5);
  assign lvl6 = (out6 & oe6) | (ext6 & ~oe6);
  // Open-drain line idles high through its pull-up
  assign kb_lvl = kb_oe ? kb_out : 1'b1;
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("wrong value at %0t: %h not %h", $time, got, exp); \
  end \
end
module testbench;
  logic                   clock = 1'b0;
  logic                   nrst = 1'b0;
  wdt_gpio_pkg::bus_req_t req = '0;
  logic [7:0]             rdata, out5, oe5, out6, oe6, lvl5, lvl6;
  logic [7:0]             ext5 = 8'h3C;
  logic [7:0]             ext6 = 8'hC3;
  logic                   rst_line = 1'b0, mirq = 1'b0, kirq = 1'b0;
  logic                   to_n, led, kb_out, kb_oe, kb_lvl;
  logic [11:0]            base;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  // Short millisecond so the fast modes finish quickly
  wdt_gpio56 #(.CYC_PER_MS(10)) dut (.clock(clock), .nrst(nrst),
    .addr(req.addr), .wdata(req.wdata), .wr(req.wr), .rd(req.rd),
    .rdata(rdata), .port_five_pins_in(lvl5), .port_five_pins_out(out5),
    .port_five_pins_oe(oe5), .port_six_pins_in(lvl6),
    .port_six_pins_out(out6), .port_six_pins_oe(oe6),
    .keyboard_ctrl_reset_line(rst_line), .mouse_irq(mirq),
    .keyboard_irq(kirq),
    .watchdog_timeout_out_n(to_n), .power_led_en(led),
    .keyboard_reset_pin_out(kb_out), .keyboard_reset_pin_oe(kb_oe),
    .io_base_addr(base));
  pin_partner far (.out5(out5), .oe5(oe5), .ext5(ext5), .lvl5(lvl5),
    .out6(out6), .oe6(oe6), .ext6(ext6), .lvl6(lvl6), .kb_out(kb_out),
    .kb_oe(kb_oe), .kb_lvl(kb_lvl));
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // One-cycle register write
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  // One-cycle register read, data taken in the answer cycle
  task automatic br(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1 d = rdata;
  endtask
  // Cycles until the timeout output goes low, bounded
  task automatic wait_to(input int lim, output int n);
    n = 0;
    // Let a write on this edge settle before the output is looked at
    #1;
    while (to_n !== 1'b0 && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  task automatic t_reset();
    logic [7:0]  v;
    logic [15:0] tbl [13] = '{16'h3002, 16'h6000, 16'h6100, 16'hE0FF,
      16'hE200, 16'hE300, 16'hE4FF, 16'hE600, 16'hE700, 16'hF500,
      16'hF600, 16'hF700, 16'h0000};
    foreach (tbl[i]) begin
      br(tbl[i][15:8], v);
      `CHK(v, tbl[i][7:0])
    end
    `CHK(out5, 8'h00)
    `CHK(out6, 8'h1F)
  endtask
  task automatic t_ports();
    logic [7:0] v, i, o;
    logic [3:0] up;
    bw(8'h30, 8'h06);
    for (int p = 0; p < 2; p++) begin
      up = p ? 4'h1 : 4'h0;
      bw(8'hE0 + 8'(4 * p), 8'hF0);
      bw(8'hE1 + 8'(4 * p), 8'hA5);
      for (int j = 0; j < 2; j++) begin
        i = j ? 8'hFF : 8'h00;
        bw(8'hE2 + 8'(4 * p), i);
        br(8'hE1 + 8'(4 * p), v);
        o = p ? out6 : out5;
        `CHK(o, {up ^ i[7:4], 4'h5 ^ i[3:0]})
        `CHK(p ? oe6 : oe5, 8'h0F)
        `CHK(v, {(p ? ext6[7:4] : ext5[7:4]) ^ i[7:4], 4'h5})
      end
    end
    bw(8'h30, 8'h05);
    #1 `CHK(oe5, 8'h00)
    `CHK(oe6, 8'h0F)
    `CHK(led, 1'b1)
  endtask
  task automatic t_edges();
    logic [7:0] v;
    bw(8'h30, 8'h02);
    bw(8'hE0, 8'hFF);
    bw(8'hE4, 8'hFF);
    br(8'hE3, v);
    @(posedge clock);
    ext5 <= ext5 ^ 8'h09;
    ext6 <= ext6 ^ 8'h81;
    br(8'hE3, v);
    `CHK(v, 8'h09)
    br(8'hE3, v);
    `CHK(v, 8'h00)
    br(8'hE7, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_count();
    logic [7:0] v;
    int         n;
    bw(8'h30, 8'h01);
    bw(8'hF5, 8'h10);
    bw(8'hF6, 8'h03);
    br(8'hF6, v);
    `CHK(v, 8'h03)
    wait_to(100, n);
    `CHK(n >= 22 && n <= 34, 1'b1)
    @(posedge clock);
    #1 `CHK(kb_lvl, 1'b1)
    br(8'hF7, v);
    `CHK(v[4], 1'b1)
    bw(8'hF7, 8'h00);
    br(8'hF7, v);
    `CHK(v[4], 1'b0)
    bw(8'hF5, 8'h12);
    bw(8'hF6, 8'h02);
    wait_to(100, n);
    repeat (2) @(posedge clock);
    #1 `CHK(kb_lvl, 1'b0)
    repeat (205) @(posedge clock);
    #1 `CHK(kb_lvl, 1'b1)
    bw(8'hF5, 8'h18);
    bw(8'hF6, 8'h01);
    wait_to(700, n);
    `CHK(n >= 590 && n <= 605, 1'b1)
    bw(8'hF5, 8'h00);
    bw(8'hF6, 8'h01);
    wait_to(10100, n);
    `CHK(n >= 9990 && n <= 10005, 1'b1)
    bw(8'hF6, 8'h00);
    repeat (50) @(posedge clock);
    #1 `CHK(to_n, 1'b1)
  endtask
  task automatic t_reload();
    logic [7:0] v;
    for (int k = 0; k < 3; k++) begin
      bw(8'hF5, 8'h10);
      bw(8'hF7, k < 2 ? 8'hC0 : 8'h00);
      bw(8'hF6, 8'h04);
      repeat (25) @(posedge clock);
      mirq <= (k != 1);
      kirq <= (k == 1);
      @(posedge clock);
      mirq <= 1'b0;
      kirq <= 1'b0;
      br(8'hF6, v);
      `CHK(v == 8'h04, k < 2)
    end
  endtask
  task automatic t_trigger();
    logic [7:0] v;
    int         n;
    bw(8'hF7, 8'h20);
    wait_to(5, n);
    `CHK(to_n, 1'b0)
    br(8'hF7, v);
    `CHK(v & 8'h30, 8'h10)
    for (int k = 0; k < 2; k++) begin
      bw(8'hF7, 8'h00);
      bw(8'hF6, 8'h00);
      bw(8'hF5, k ? 8'h00 : 8'h04);
      rst_line <= 1'b1;
      repeat (4) @(posedge clock);
      rst_line <= 1'b0;
      #1 `CHK(to_n, 1'(k))
    end
    bw(8'h30, 8'h00);
    bw(8'hF7, 8'h20);
    repeat (3) @(posedge clock);
    #1 `CHK(to_n, 1'b1)
    `CHK(led, 1'b0)
  endtask
  task automatic t_base();
    logic [7:0] v;
    bw(8'h60, 8'hFF);
    bw(8'h61, 8'hFF);
    bw(8'h00, 8'h55);
    `CHK(base, 12'hFFC)
    br(8'h61, v);
    `CHK(v, 8'hFC)
    br(8'h00, v);
    `CHK(v, 8'h00)
  endtask
  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_ports();
    t_edges();
    t_count();
    t_reload();
    t_trigger();
    t_base();
    complete_run();
  end
endmodule
bind wdt_gpio56 wdt_gpio56_sva #(.CYC_PER_MS(CYC_PER_MS)) chk (.*);

// [wdt_gpio56.sv]
`timescale 1ns/1ps
module wdt_gpio56 #(
  parameter longint CYC_PER_SEC = wdt_gpio_pkg::CYC_PER_SEC,
  parameter longint CYC_PER_MS  = wdt_gpio_pkg::CYC_PER_MS
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  port_five_pins_in,
  output logic      [7:0]  port_five_pins_out,
  output logic      [7:0]  port_five_pins_oe,
  input  wire logic [7:0]  port_six_pins_in,
  output logic      [7:0]  port_six_pins_out,
  output logic      [7:0]  port_six_pins_oe,
  input  wire logic        keyboard_ctrl_reset_line,
  input  wire logic        mouse_irq,
  input  wire logic        keyboard_irq,
  output logic             watchdog_timeout_out_n,
  output logic             power_led_en,
  output logic             keyboard_reset_pin_out,
  output logic             keyboard_reset_pin_oe,
  output logic      [11:0] io_base_addr
);

  // Bus request bundle
  wdt_gpio_pkg::bus_req_t req;
  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // Register state
  logic [7:0]  activation;       // Unit enables
  logic [7:0]  base_high;        // Base address upper byte
  logic [7:0]  base_low;         // Base address lower byte
  logic [7:0]  p5_dir;           // Port five direction
  logic [7:0]  p5_data;          // Port five output latch
  logic [7:0]  p5_inv;           // Port five inversion
  logic [7:0]  p5_status;        // Port five edge status
  logic [7:0]  p6_dir;           // Port six direction
  logic [7:0]  p6_data;          // Port six output latch
  logic [7:0]  p6_inv;           // Port six inversion
  logic [7:0]  p6_status;        // Port six edge status
  logic [7:0]  wd_mode;          // Count mode
  logic [7:0]  wd_reload;        // Last non-zero timeout value
  logic [7:0]  wd_count;         // Live down-counter
  logic [7:0]  wd_ctrl;          // Enables and status
  logic [7:0]  p5_prev;          // Previous port five sample
  logic [7:0]  p6_prev;          // Previous port six sample
  logic        line_prev;        // Previous reset-line sample
  logic [27:0] ms_div;           // Millisecond-tick divider
  logic [5:0]  sec_div;          // Seconds within a minute, or ms within 60 ms in fast mode
  logic [9:0]  tick_div;         // Sub-units toward a whole unit
  logic [31:0] pulse_cnt;        // Keyboard reset pulse length
  logic        timeout_lvl;      // Timeout output level

  // Decodes
  wire hit_p5_data  = req.addr == wdata_sel(wdt_gpio_pkg::OFF_P5_DATA);
  wire hit_p6_data  = req.addr == wdt_gpio_pkg::OFF_P6_DATA;
  wire wr_counter   = req.wr && req.addr == wdt_gpio_pkg::OFF_WD_COUNTER;
  wire wr_ctrl      = req.wr && req.addr == wdt_gpio_pkg::OFF_WD_CTRL;
  wire rd_p5_status = req.rd && req.addr == wdt_gpio_pkg::OFF_P5_STATUS;
  wire rd_p6_status = req.rd && req.addr == wdt_gpio_pkg::OFF_P6_STATUS;
  wire wdt_active   = activation[wdt_gpio_pkg::ACT_WDT_BIT];
  wire p5_active    = activation[wdt_gpio_pkg::ACT_P5_BIT];
  wire p6_active    = activation[wdt_gpio_pkg::ACT_P6_BIT];

  // Identity helper keeps decode uniform
  function automatic logic [7:0] wdata_sel(input logic [7:0] a);
    return a;
  endfunction

  // Merge write: only output bits (dir 0) take new data
  function automatic logic [7:0] merge_out(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] dir);
    return (old_v & dir) | (new_v & ~dir);
  endfunction

  // Data register read view: inputs show pins through inversion
  function automatic logic [7:0] data_view(input logic [7:0] latch,
                                           input logic [7:0] pins,
                                           input logic [7:0] dir,
                                           input logic [7:0] inv);
    return (latch & ~dir) | ((pins ^ inv) & dir);
  endfunction

  // Edges seen on input pins of an active port
  function automatic logic [7:0] edges(input logic [7:0] now_v,
                                       input logic [7:0] prev,
                                       input logic [7:0] dir,
                                       input logic       act);
    return (now_v ^ prev) & dir & {8{act}};
  endfunction

  // Pin drive: outputs on active port only, inversion applied
  assign port_five_pins_out = p5_data ^ p5_inv;
  assign port_five_pins_oe  = ~p5_dir & {8{p5_active}};
  assign port_six_pins_out  = p6_data ^ p6_inv;
  assign port_six_pins_oe   = ~p6_dir & {8{p6_active}};

  // Base address, low two bits forced zero for alignment
  assign io_base_addr = {base_high[3:0], base_low};

  // Unit clock: ms tick, then seconds, then minutes
  wire ms_tick  = ms_div == 28'(CYC_PER_MS - 1);
  wire sec_tick = ms_tick && tick_div == 10'(wdt_gpio_pkg::TICKS_PER_SEC - 1);
  wire min_tick = sec_tick && sec_div == 6'(wdt_gpio_pkg::SEC_PER_MIN - 1);
  wire fast     = wd_mode[wdt_gpio_pkg::MODE_FAST_BIT];
  wire minutes  = wd_mode[wdt_gpio_pkg::MODE_MIN_BIT];
  // Fast: 1 ms or 60 ms; normal: 1 s or 1 min
  wire fast_min = ms_tick && sec_div == 6'(wdt_gpio_pkg::SEC_PER_MIN - 1);
  wire unit_tick = fast ? (minutes ? fast_min : ms_tick)
                        : (minutes ? min_tick : sec_tick);

  // Timeout causes
  wire line_rise = keyboard_ctrl_reset_line && !line_prev;
  wire irq_reload =
    (mouse_irq && wd_ctrl[wdt_gpio_pkg::CTRL_MOUSE_BIT]) ||
    (keyboard_irq && wd_ctrl[wdt_gpio_pkg::CTRL_KBD_BIT]);
  wire count_end = unit_tick && wd_count == 8'h01;
  wire force_to  = wr_ctrl && req.wdata[wdt_gpio_pkg::CTRL_TRIG_BIT];
  wire line_to   = line_rise && wd_mode[wdt_gpio_pkg::MODE_LINE_BIT];
  wire timeout_ev = wdt_active && (count_end || force_to || line_to);

  // Read mux
  logic [7:0] next_rdata;
  always_comb begin
    case (req.addr)
      wdt_gpio_pkg::OFF_ACTIVATION: next_rdata = activation;
      wdt_gpio_pkg::OFF_BASE_HIGH:  next_rdata = base_high;
      wdt_gpio_pkg::OFF_BASE_LOW:   next_rdata = base_low;
      wdt_gpio_pkg::OFF_P5_DIR:     next_rdata = p5_dir;
      wdt_gpio_pkg::OFF_P5_DATA:    next_rdata =
        data_view(p5_data, port_five_pins_in, p5_dir, p5_inv);
      wdt_gpio_pkg::OFF_P5_INV:     next_rdata = p5_inv;
      wdt_gpio_pkg::OFF_P5_STATUS:  next_rdata = p5_status;
      wdt_gpio_pkg::OFF_P6_DIR:     next_rdata = p6_dir;
      wdt_gpio_pkg::OFF_P6_DATA:    next_rdata =
        data_view(p6_data, port_six_pins_in, p6_dir, p6_inv);
      wdt_gpio_pkg::OFF_P6_INV:     next_rdata = p6_inv;
      wdt_gpio_pkg::OFF_P6_STATUS:  next_rdata = p6_status;
      wdt_gpio_pkg::OFF_WD_MODE:    next_rdata = wd_mode;
      wdt_gpio_pkg::OFF_WD_COUNTER: next_rdata = wd_count;
      wdt_gpio_pkg::OFF_WD_CTRL:    next_rdata = wd_ctrl;
      default:                      next_rdata = wdt_gpio_pkg::RST_ZERO;
    endcase
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= wdt_gpio_pkg::RST_ZERO;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= wdt_gpio_pkg::RST_ZERO;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      activation <= wdt_gpio_pkg::RST_ACTIVATION;
      base_high  <= wdt_gpio_pkg::RST_ZERO;
      base_low   <= wdt_gpio_pkg::RST_ZERO;
      p5_dir     <= wdt_gpio_pkg::RST_DIR;
      p6_dir     <= wdt_gpio_pkg::RST_DIR;
      p5_inv     <= wdt_gpio_pkg::RST_ZERO;
      p6_inv     <= wdt_gpio_pkg::RST_ZERO;
      wd_mode    <= wdt_gpio_pkg::RST_ZERO;
    end else if (req.wr) begin
      case (req.addr)
        wdt_gpio_pkg::OFF_ACTIVATION:
          activation <= req.wdata & wdt_gpio_pkg::MASK_ACTIVATION;
        wdt_gpio_pkg::OFF_BASE_HIGH:
          base_high <= req.wdata & wdt_gpio_pkg::MASK_BASE_HIGH;
        wdt_gpio_pkg::OFF_BASE_LOW:
          base_low <= req.wdata & wdt_gpio_pkg::MASK_BASE_LOW;
        wdt_gpio_pkg::OFF_P5_DIR: p5_dir <= req.wdata;
        wdt_gpio_pkg::OFF_P6_DIR: p6_dir <= req.wdata;
        wdt_gpio_pkg::OFF_P5_INV: p5_inv <= req.wdata;
        wdt_gpio_pkg::OFF_P6_INV: p6_inv <= req.wdata;
        wdt_gpio_pkg::OFF_WD_MODE:
          wd_mode <= req.wdata & wdt_gpio_pkg::MASK_WD_MODE;
        default: ;
      endcase
    end
  end

  // Data latches: input bits ignore writes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      p5_data <= wdt_gpio_pkg::RST_P5_DATA;
      p6_data <= wdt_gpio_pkg::RST_P6_DATA;
    end else begin
      if (req.wr && hit_p5_data)
        p5_data <= merge_out(p5_data, req.wdata, p5_dir);
      if (req.wr && hit_p6_data)
        p6_data <= merge_out(p6_data, req.wdata, p6_dir);
    end
  end

  // Edge status: set wins over read-clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Track the pins through reset so no false edge follows it
      p5_prev   <= port_five_pins_in;
      p6_prev   <= port_six_pins_in;
      p5_status <= wdt_gpio_pkg::RST_ZERO;
      p6_status <= wdt_gpio_pkg::RST_ZERO;
    end else begin
      p5_prev   <= port_five_pins_in;
      p6_prev   <= port_six_pins_in;
      p5_status <= (rd_p5_status ? 8'h00 : p5_status)
        | edges(port_five_pins_in, p5_prev, p5_dir, p5_active);
      p6_status <= (rd_p6_status ? 8'h00 : p6_status)
        | edges(port_six_pins_in, p6_prev, p6_dir, p6_active);
    end
  end

  // Time-base dividers, restarted on every load
  always_ff @(posedge clock) begin
    if (!nrst || wr_counter || irq_reload) begin
      ms_div   <= '0;
      tick_div <= '0;
      sec_div  <= '0;
    end else begin
      ms_div <= ms_tick ? '0 : ms_div + 28'd1;
      if (ms_tick)
        tick_div <= sec_tick ? '0 : tick_div + 10'd1;
      if (fast ? ms_tick : sec_tick)
        sec_div <= (sec_div == 6'(wdt_gpio_pkg::SEC_PER_MIN - 1))
                   ? '0 : sec_div + 6'd1;
    end
  end

  // Down-counter and reload value
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wd_count  <= wdt_gpio_pkg::RST_ZERO;
      wd_reload <= wdt_gpio_pkg::RST_ZERO;
      line_prev <= 1'b0;
    end else begin
      line_prev <= keyboard_ctrl_reset_line;
      if (wr_counter) begin
        wd_count <= req.wdata;
        if (req.wdata != 8'h00)
          wd_reload <= req.wdata;
      end else if (irq_reload && wd_reload != 8'h00) begin
        wd_count <= wd_reload;
      end else if (unit_tick && wd_count != 8'h00) begin
        wd_count <= wd_count - 8'd1;
      end
    end
  end

  // Control/status: timeout flag set wins over clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wd_ctrl <= wdt_gpio_pkg::RST_ZERO;
    end else begin
      if (wr_ctrl)
        wd_ctrl <= (req.wdata & wdt_gpio_pkg::MASK_WD_CTRL_RW)
                 | ({7'h00, req.wdata[wdt_gpio_pkg::CTRL_STAT_BIT]} << 4
                    & {3'h0, wd_ctrl[wdt_gpio_pkg::CTRL_STAT_BIT], 4'h0})
                 | ({7'h00, timeout_ev} << 4);
      else if (timeout_ev)
        wd_ctrl[wdt_gpio_pkg::CTRL_STAT_BIT] <= 1'b1;
    end
  end

  // Timeout output level and keyboard reset pulse
  always_ff @(posedge clock) begin
    if (!nrst) begin
      timeout_lvl <= 1'b0;
      pulse_cnt   <= '0;
    end else begin
      if (timeout_ev)
        timeout_lvl <= 1'b1;
      else if (wr_counter || irq_reload || !wdt_active)
        timeout_lvl <= 1'b0;
      if (timeout_ev && wd_mode[wdt_gpio_pkg::MODE_RSTPULSE_BIT])
        pulse_cnt <= 32'(wdt_gpio_pkg::RSTPULSE_CYC);
      else if (pulse_cnt != '0)
        pulse_cnt <= pulse_cnt - 32'd1;
    end
  end

  // Pins: timeout output low while active and timed out
  assign watchdog_timeout_out_n = !(timeout_lvl && wdt_active);
  assign power_led_en           = wdt_active;
  assign keyboard_reset_pin_out = 1'b0;
  assign keyboard_reset_pin_oe  = pulse_cnt != '0;

endmodule

// [wdt_gpio56_sva.sv]
`timescale 1ns/1ps
// Port-level checks on the watchdog and port unit
module wdt_gpio56_sva #(
  parameter longint CYC_PER_MS = 10
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic [7:0]  port_five_pins_in,
  input wire logic [7:0]  port_five_pins_oe,
  input wire logic [7:0]  port_six_pins_oe,
  input wire logic        watchdog_timeout_out_n,
  input wire logic        power_led_en,
  input wire logic        keyboard_reset_pin_oe,
  input wire logic [11:0] io_base_addr
);
  // Length of the running keyboard reset pulse
  int pulse_len;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pulse_len <= 0;
    end else begin
      pulse_len <= keyboard_reset_pin_oe ? pulse_len + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_read_idle:
    assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside the answer cycle");
  a_oe_after_reset:
    assert property ($rose(nrst) |-> port_five_pins_oe == 8'h00
      && port_six_pins_oe == 8'h00) else $error("pins driven after reset");
  a_timeout_needs_led:
    assert property (!watchdog_timeout_out_n |-> power_led_en)
      else $error("timeout low while inactive");
  a_rstpulse_cause:
    assert property ($rose(keyboard_reset_pin_oe) |-> !watchdog_timeout_out_n)
      else $error("reset pulse without timeout");
  a_rstpulse_length:
    assert property ($fell(keyboard_reset_pin_oe)
      |-> pulse_len == wdt_gpio_pkg::RSTPULSE_CYC)
      else $error("reset pulse length wrong");
  a_status_read_clear:
    assert property (rd && addr == 8'hE3 ##2 rd && addr == 8'hE3
      && $stable(port_five_pins_in)
      && $past(port_five_pins_in, 2) == port_five_pins_in
      && $past(port_five_pins_in, 3) == port_five_pins_in
      |=> rdata == 8'h00) else $error("status not cleared by read");
  a_force_timeout:
    assert property (wr && addr == 8'hF7 && wdata[5] && power_led_en
      |-> ##[1:2] !watchdog_timeout_out_n) else $error("forced timeout lost");
  a_base_low_write:
    assert property (wr && addr == 8'h61
      |=> io_base_addr[7:0] == ($past(wdata) & 8'hFC))
      else $error("base address low byte wrong");
  a_count_load:
    assert property (wr && addr == 8'hF6 && wdata != 8'h00
      ##2 rd && addr == 8'hF6 |=> rdata == $past(wdata, 3)
      || rdata == $past(wdata, 3) - 8'h01) else $error("counter not loaded");
  c_timeout: cover property ($fell(watchdog_timeout_out_n));
  c_rstpulse: cover property ($fell(keyboard_reset_pin_oe));
  c_status: cover property (rd && addr == 8'hE3 ##1 rdata != 8'h00);
endmodule

// [wdt_gpio_pkg.sv]
package wdt_gpio_pkg;

  // Register offsets (config register index)
  localparam logic [7:0] OFF_ACTIVATION = 8'h30;
  localparam logic [7:0] OFF_BASE_HIGH  = 8'h60;
  localparam logic [7:0] OFF_BASE_LOW   = 8'h61;
  localparam logic [7:0] OFF_P5_DIR     = 8'hE0;
  localparam logic [7:0] OFF_P5_DATA    = 8'hE1;
  localparam logic [7:0] OFF_P5_INV     = 8'hE2;
  localparam logic [7:0] OFF_P5_STATUS  = 8'hE3;
  localparam logic [7:0] OFF_P6_DIR     = 8'hE4;
  localparam logic [7:0] OFF_P6_DATA    = 8'hE5;
  localparam logic [7:0] OFF_P6_INV     = 8'hE6;
  localparam logic [7:0] OFF_P6_STATUS  = 8'hE7;
  localparam logic [7:0] OFF_WD_MODE    = 8'hF5;
  localparam logic [7:0] OFF_WD_COUNTER = 8'hF6;
  localparam logic [7:0] OFF_WD_CTRL    = 8'hF7;

  // Reset values
  localparam logic [7:0] RST_ACTIVATION = 8'h02;
  localparam logic [7:0] RST_DIR        = 8'hFF;
  localparam logic [7:0] RST_P5_DATA    = 8'h00;
  localparam logic [7:0] RST_P6_DATA    = 8'h1F;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // Writable-bit masks
  localparam logic [7:0] MASK_ACTIVATION = 8'h07;
  localparam logic [7:0] MASK_WD_MODE    = 8'h1E;
  localparam logic [7:0] MASK_BASE_LOW   = 8'hFC;
  localparam logic [7:0] MASK_BASE_HIGH  = 8'h0F;
  localparam logic [7:0] MASK_WD_CTRL_RW = 8'hCF;

  // Field positions
  localparam int ACT_WDT_BIT    = 0;
  localparam int ACT_P5_BIT     = 1;
  localparam int ACT_P6_BIT     = 2;
  localparam int MODE_RSTPULSE_BIT = 1;
  localparam int MODE_LINE_BIT     = 2;
  localparam int MODE_MIN_BIT   = 3;
  localparam int MODE_FAST_BIT  = 4;
  localparam int CTRL_STAT_BIT  = 4;
  localparam int CTRL_TRIG_BIT  = 5;
  localparam int CTRL_KBD_BIT   = 6;
  localparam int CTRL_MOUSE_BIT = 7;

  // Timing
  localparam longint CLOCK_HZ       = 64'd200_000_000;
  localparam longint MS_PER_SEC     = 64'd1000;
  localparam longint SEC_PER_MIN    = 64'd60;
  localparam longint CYC_PER_MS     = CLOCK_HZ / MS_PER_SEC;
  localparam longint CYC_PER_SEC    = CLOCK_HZ;
  localparam longint TICKS_PER_SEC  = MS_PER_SEC;
  localparam real    RSTPULSE_NS  = 1000.0;
  localparam int     RSTPULSE_CYC =
    int'((RSTPULSE_NS * real'(CLOCK_HZ)) / 1.0e9);

  // Bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

endpackage
